// ==== include/crdc_pkg.sv ====
// Package for the core rail voltage-change control block.
// Assumes one 200 MHz system clock and a decoded serial-interface register port.
package crdc_pkg;

    // Register offsets on the serial interface
    localparam logic [7:0] ADDR_CONVERTER_CONTROL_TWO = 8'h05;
    localparam logic [7:0] ADDR_CORE_TARGET_VOLTAGE   = 8'h06;
    localparam logic [7:0] ADDR_CORE_SLEW_SELECT      = 8'h07;

    // Field positions in converter_control_two
    localparam int BIT_APPLY_CHANGE = 7;
    localparam int BIT_PIN_SELECT   = 6;
    localparam int DISCHARGE_MSB    = 2;

    // Values after reset, and the immediate slew code
    localparam logic [7:0] RST_CONVERTER_CONTROL_TWO = 8'h40;
    localparam logic [7:0] RST_CORE_SLEW_SELECT      = 8'h06;
    localparam logic [7:0] RST_TARGET_STRAP_LOW      = 8'h14;
    localparam logic [7:0] RST_TARGET_STRAP_HIGH     = 8'h1E;
    localparam logic [2:0] SLEW_IMMEDIATE            = 3'h7;

    // Step timing: one 25 mV count at the slowest rate of 0.225 mV/us
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int SLOWEST_STEP_PS    = 111111112;
    localparam int SLOWEST_STEP_CYCLES =
        (SLOWEST_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Decoded register access from the serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crdc_bus_s;

endpackage

// ==== core/crdc_step_timer.sv ====
// Step pacing timer for the core voltage ramp.
// Assumes the slew code stays stable while a ramp is in progress.
`timescale 1ns/100ps
module crdc_step_timer
    import crdc_pkg::*;
#(
    parameter int CNT_W      = 15,
    parameter int BASE_STEPS = SLOWEST_STEP_CYCLES
) (
    input  wire logic       i_sys_clk,  // System clock
    input  wire logic       i_reset_n,  // Async reset, active low
    input  wire logic       i_run,      // Count while high
    input  wire logic [2:0] i_slew,     // Slew code, halves period per count
    output logic            o_tick      // One-cycle step pulse
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reload;

    // Period halves for each slew count, never below one cycle
    assign reload = CNT_W'((BASE_STEPS >> i_slew) - 1);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            count  <= reload;
            o_tick <= 1'b0;
        end else if (count == '0) begin
            count  <= reload;
            o_tick <= 1'b1;
        end else begin
            count  <= count - CNT_W'(1);
            o_tick <= 1'b0;
        end
    end
endmodule

// ==== core/crdc_core.sv ====
// Core rail dynamic voltage change control: registers 05h..07h and code ramp.
// Assumes register strobes arrive already decoded from the serial interface.
// Operation
// - Apply bit ramps code to target at slew
// - Apply bit self-clears when transition done
// - Done means code reached, not rail settled
// - Pin-select picks strap or register voltage
// - Strap low gives 1.3 V, high 1.55 V
// - Pin-select returns to 1 on reset events
// - Discharge bits act while converter disabled
// - Target code is 0.8 V plus 25 mV
// - Target resets to 14h or 1Eh by strap
// - Target reloads on all reset events
// - Slew codes double rate, 111 immediate
// - Slew register resets 06h, three bits
// - Control register resets 40h, bits 5:3 zero
`timescale 1ns/100ps
module crdc_core
    import crdc_pkg::*;
#(
    parameter int STEP_CYCLES = SLOWEST_STEP_CYCLES
) (
    input  wire logic       i_sys_clk,              // System clock, 200 MHz
    input  wire logic       i_reset_n,              // Async reset, active low
    input  wire crdc_bus_s  i_bus,                  // Decoded register access
    input  wire logic       i_undervoltage_lockout, // Lockout active
    input  wire logic       i_warm_reset_pin_n,     // Warm reset pin, low active
    input  wire logic       i_power_on_reset_output,// Power-on reset active
    input  wire logic       i_backup_clock_rail_low,// Backup rail under threshold
    input  wire logic       i_core_default_strap,   // Strap pin at supply
    input  wire logic [2:0] i_converter_enable,     // System, core, memory enables
    output logic      [7:0] o_rdata,                // Register read data
    output logic      [4:0] o_core_rail_voltage,    // Internal voltage code
    output logic            o_core_use_strap,       // Voltage taken from strap
    output logic      [2:0] o_discharge,            // Active discharge on
    output logic            o_dvm_busy              // Apply bit still set
);
    typedef enum logic [0:0] {S_IDLE, S_RAMP} crdc_state_e;

    crdc_state_e state;
    logic        load_pending;
    logic        apply_change;
    logic        pin_select;
    logic [2:0]  discharge_en;
    logic [4:0]  target;
    logic [2:0]  slew;
    logic [4:0]  code;
    logic        tick;
    logic        done;
    logic        undervoltage_lockout_load;
    logic        rail_load;
    logic        wr_ctrl;
    logic [7:0]  strap_default;

    // Full default load on lockout and once after async reset
    assign undervoltage_lockout_load = i_undervoltage_lockout | load_pending;
    assign rail_load = undervoltage_lockout_load | !i_warm_reset_pin_n | i_power_on_reset_output | i_backup_clock_rail_low;
    assign wr_ctrl   = i_bus.wr && (i_bus.addr == ADDR_CONVERTER_CONTROL_TWO);
    assign strap_default = i_core_default_strap ? RST_TARGET_STRAP_HIGH : RST_TARGET_STRAP_LOW;

    // Code reached target ends the ramp, rail settling not awaited
    assign done = apply_change &&
                  ((state == S_IDLE && slew == SLEW_IMMEDIATE) || (state == S_RAMP && code == target));

    // Strap caught by the clock after reset release
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            load_pending <= 1'b1;
        end else begin
            load_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            apply_change <= RST_CONVERTER_CONTROL_TWO[BIT_APPLY_CHANGE];
        end else if (undervoltage_lockout_load) begin
            apply_change <= 1'b0;
        end else if (wr_ctrl) begin
            apply_change <= i_bus.wdata[BIT_APPLY_CHANGE];
        end else if (done) begin
            apply_change <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_select <= RST_CONVERTER_CONTROL_TWO[BIT_PIN_SELECT];
        end else if (rail_load) begin
            pin_select <= RST_CONVERTER_CONTROL_TWO[BIT_PIN_SELECT];
        end else if (wr_ctrl) begin
            pin_select <= i_bus.wdata[BIT_PIN_SELECT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            discharge_en <= RST_CONVERTER_CONTROL_TWO[DISCHARGE_MSB:0];
        end else if (undervoltage_lockout_load) begin
            discharge_en <= RST_CONVERTER_CONTROL_TWO[DISCHARGE_MSB:0];
        end else if (wr_ctrl) begin
            discharge_en <= i_bus.wdata[DISCHARGE_MSB:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            target <= RST_TARGET_STRAP_LOW[4:0];
        end else if (rail_load) begin
            target <= strap_default[4:0];
        end else if (i_bus.wr && i_bus.addr == ADDR_CORE_TARGET_VOLTAGE) begin
            target <= i_bus.wdata[4:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            slew <= RST_CORE_SLEW_SELECT[2:0];
        end else if (undervoltage_lockout_load) begin
            slew <= RST_CORE_SLEW_SELECT[2:0];
        end else if (i_bus.wr && i_bus.addr == ADDR_CORE_SLEW_SELECT) begin
            slew <= i_bus.wdata[2:0];
        end
    end

    crdc_step_timer #(
        .CNT_W      (15),
        .BASE_STEPS (STEP_CYCLES)
    ) u_step_timer (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_run     (state == S_RAMP),
        .i_slew    (slew),
        .o_tick    (tick)
    );

    // Ramp sequencer; software clearing the apply bit stops the ramp
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= S_IDLE;
        end else if (rail_load) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (apply_change && slew != SLEW_IMMEDIATE) begin
                        state <= S_RAMP;
                    end
                end
                S_RAMP: begin
                    if (!apply_change || code == target) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            code <= RST_TARGET_STRAP_LOW[4:0];
        end else if (rail_load) begin
            code <= strap_default[4:0];
        end else if (state == S_IDLE && apply_change && slew == SLEW_IMMEDIATE) begin
            code <= target;
        end else if (state == S_RAMP && apply_change && tick && code != target) begin
            code <= (code < target) ? code + 5'h1 : code - 5'h1;
        end
    end

    // Discharge only while the converter is off
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_discharge <= 3'h0;
        end else begin
            o_discharge <= discharge_en & ~i_converter_enable;
        end
    end

    // Unused bits read as zero
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                ADDR_CONVERTER_CONTROL_TWO: o_rdata <= {apply_change, pin_select, 3'h0, discharge_en};
                ADDR_CORE_TARGET_VOLTAGE:   o_rdata <= {3'h0, target};
                ADDR_CORE_SLEW_SELECT:      o_rdata <= {5'h0, slew};
                default:                    o_rdata <= 8'h00;
            endcase
        end
    end

    assign o_core_rail_voltage = code;
    assign o_core_use_strap    = pin_select;
    assign o_dvm_busy          = apply_change;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    a_apply_self_clear: assert property (
        done && !wr_ctrl |=> !apply_change)
        else $error("Apply bit not cleared after transition end");

    a_done_on_code: assert property (
        state == S_RAMP && apply_change && code == target && !rail_load |=> state == S_IDLE && !apply_change)
        else $error("Ramp did not end when code reached target");

    a_step_one_count: assert property (
        state == S_RAMP && apply_change && tick && code != target && !rail_load
        |=> (code == $past(code) + 5'h1) || (code == $past(code) - 5'h1))
        else $error("Ramp step was not one count");

    a_hold_between_ticks: assert property (
        state == S_RAMP && !tick && !rail_load |=> $stable(code))
        else $error("Code moved without a step tick");

    a_immediate_apply: assert property (
        state == S_IDLE && apply_change && slew == SLEW_IMMEDIATE && !rail_load
        |=> code == $past(target) ##1 state == S_IDLE)
        else $error("Immediate slew did not jump to target");

    a_lockout_defaults: assert property (
        i_undervoltage_lockout |=> slew == 3'h6 && discharge_en == 3'h0 && !apply_change)
        else $error("Lockout did not load defaults");

    a_pin_select_reload: assert property (
        !i_warm_reset_pin_n || i_power_on_reset_output || i_backup_clock_rail_low |=> o_core_use_strap)
        else $error("Pin select not restored on reset event");

    a_target_reload: assert property (
        rail_load |=> target == {1'b1, $past(i_core_default_strap), $past(i_core_default_strap), 2'b10}
                      || (!$past(i_core_default_strap) && target == 5'h14))
        else $error("Target not reloaded from strap");

    a_discharge_gate: assert property (
        discharge_en[1] && !i_converter_enable[1] |=> o_discharge[1])
        else $error("Core discharge not active while disabled");

    a_unused_read_zero: assert property (
        i_bus.rd && i_bus.addr == ADDR_CONVERTER_CONTROL_TWO |=> o_rdata[5:3] == 3'h0)
        else $error("Unused control bits read nonzero");
endmodule

// ==== tb/crdc_host_model.sv ====
// Host model that reaches the block's registers over the decoded serial port.
// Assumes the bench calls its tasks from one process, after reset release.
`timescale 1ns/100ps
module crdc_host_model
    import crdc_pkg::*;
(
    input  wire logic       i_sys_clk, // System clock
    input  wire logic [7:0] i_rdata,   // Read data from block
    output crdc_bus_s       o_bus      // Decoded register access
);
    initial o_bus = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

    // Idle lines show the inverse pattern, never the last value
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_sys_clk) #1;
        o_bus = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_sys_clk) #1;
        o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_sys_clk) #1;
        o_bus = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge i_sys_clk) #1;
        data = i_rdata;
        o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
    endtask
endmodule

// ==== tb/tb_core_rail_dvm_control.sv ====
// Self-checking bench for the core rail voltage-change control.
// Assumes the host model drives the register port and the bench drives events.
`timescale 1ns/100ps
module tb_core_rail_dvm_control;
    import crdc_pkg::*;
    logic       i_sys_clk;
    logic       i_reset_n;
    logic       undervoltage_lockout, warm_n, por, rtc_low, strap;
    logic [2:0] conv_en, disch;
    logic [4:0] code;
    logic [7:0] rdata, d;
    logic       use_strap, busy;
    crdc_bus_s  bus;
    int         bad_count = 0;
    int         tests_run = 0;
    int         cycles = 0;

    crdc_core #(.STEP_CYCLES(64)) dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_bus(bus),
        .i_undervoltage_lockout(undervoltage_lockout), .i_warm_reset_pin_n(warm_n), .i_power_on_reset_output(por),
        .i_backup_clock_rail_low(rtc_low), .i_core_default_strap(strap), .i_converter_enable(conv_en),
        .o_rdata(rdata), .o_core_rail_voltage(code), .o_core_use_strap(use_strap),
        .o_discharge(disch), .o_dvm_busy(busy));
    crdc_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_bus(bus));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        host.read_reg(addr, d);
        check($sformatf("reg %h", addr), d, exp);
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reset_values();
        check("code", {3'h0, code}, RST_TARGET_STRAP_LOW);
        rchk(8'h05, 8'h40);
        rchk(8'h06, 8'h14);
        rchk(8'h07, 8'h06);
        rchk(8'h08, 8'h00);
        host.write_reg(8'h07, 8'hFF);
        rchk(8'h07, 8'h07);
        host.write_reg(8'h06, 8'hFF);
        rchk(8'h06, 8'h1F);
    endtask

    task automatic immediate_change();
        host.write_reg(8'h07, 8'h07);
        host.write_reg(8'h05, 8'h80);
        repeat (2) @(posedge i_sys_clk) #1;
        check("code imm", {3'h0, code}, 8'h1F);
        check("busy imm", {7'h0, busy}, 8'h00);
        check("use_strap", {7'h0, use_strap}, 8'h00);
        rchk(8'h05, 8'h00);
    endtask

    task automatic slow_ramp();
        int         n;
        logic [4:0] prev;
        host.write_reg(8'h07, 8'h05);
        host.write_reg(8'h06, 8'h1B);
        host.write_reg(8'h05, 8'h80);
        check("code held", {3'h0, code}, 8'h1F);
        prev = code;
        for (n = 0; n < 60 && busy !== 1'b0; n++) begin
            @(posedge i_sys_clk) #1;
            check("step", {7'h0, (prev - code) <= 5'd1}, 8'h01);
            prev = code;
        end
        check("ramp len", {7'h0, n >= 8 && n <= 14}, 8'h01);
        check("code end", {3'h0, code}, 8'h1B);
        rchk(8'h05, 8'h00);
    endtask

    task automatic discharge();
        conv_en = 3'b101;
        host.write_reg(8'h05, 8'h07);
        repeat (2) @(posedge i_sys_clk) #1;
        check("discharge", {5'h0, disch}, 8'h02);
        conv_en = 3'b000;
        repeat (2) @(posedge i_sys_clk) #1;
        check("discharge off", {5'h0, disch}, 8'h07);
        rchk(8'h05, 8'h07);
    endtask

    task automatic reload_events();
        strap = 1'b1;
        for (int k = 0; k < 3; k++) begin
            host.write_reg(8'h06, 8'h03);
            host.write_reg(8'h05, 8'h07);
            @(posedge i_sys_clk) #1;
            warm_n = (k != 0);
            por = (k == 1);
            rtc_low = (k == 2);
            @(posedge i_sys_clk) #1;
            {warm_n, por, rtc_low} = 3'b100;
            check("strap sel", {7'h0, use_strap}, 8'h01);
            check("code rel", {3'h0, code}, RST_TARGET_STRAP_HIGH);
            rchk(8'h06, 8'h1E);
            rchk(8'h05, 8'h47);
        end
        @(posedge i_sys_clk) #1;
        undervoltage_lockout = 1'b1;
        @(posedge i_sys_clk) #1;
        undervoltage_lockout = 1'b0;
        rchk(8'h05, 8'h40);
        rchk(8'h07, 8'h06);
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        {i_reset_n, undervoltage_lockout, warm_n, por, rtc_low, strap} = 6'b001000;
        conv_en = 3'b111;
        repeat (10) @(posedge i_sys_clk);
        #1 i_reset_n = 1'b1;
        repeat (2) @(posedge i_sys_clk) #1;
        reset_values();
        immediate_change();
        slow_ramp();
        discharge();
        reload_events();
        give_verdict();
    end
endmodule
